// file: hdl/ocb_pkg.sv
// package: register map, field positions, reset values and timing counts for the output control block
package ocb_pkg;
  // ===========================================================================
  // register map
  localparam logic [12:0] OCB_ADDR_OUT_CTRL = 13'h1014;
  localparam logic [12:0] OCB_ADDR_BOOT_LO = 13'h0000;
  localparam int OCB_BOOT_WORDS = 512;
  localparam int OCB_BOOT_AW = 9;
  // ===========================================================================
  // field positions and reset value
  localparam int OCB_BIT_BUSY_EN = 0;
  localparam int OCB_BIT_KEY_LATCH = 4;
  localparam logic [7:0] OCB_OUT_CTRL_RESET = 8'h01;
  // only busy enable and key latch take a write; bits 1-3 and 5-7 stay zero
  localparam logic [7:0] OCB_OUT_CTRL_WMASK = 8'h11;
  // ===========================================================================
  // timing
  localparam int OCB_CLK_MHZ = 50;
  localparam int OCB_DOWNLOAD_NS = 2000;
  localparam int OCB_DOWNLOAD_CYC = (OCB_DOWNLOAD_NS * OCB_CLK_MHZ + 999) / 1000;
  localparam int OCB_CNT_W = 8;
endpackage : ocb_pkg

// file: hdl/ocb_strobe_if.sv
// interface: synchronised host strobes passed from the pin stage to the register logic
`timescale 1ns/100ps
interface ocb_strobe_if;
  logic cs;
  logic oe;
  logic we;
  logic avd;
  logic [12:0] addr;
  logic [15:0] wdata;
  modport src (output cs, output oe, output we, output avd, output addr, output wdata);
  modport dst (input cs, input oe, input we, input avd, input addr, input wdata);
endinterface : ocb_strobe_if

// file: hdl/ocb_pin_sync.sv
// two-flop synchroniser for the asynchronous host bus pins
`timescale 1ns/100ps
module ocb_pin_sync
  import ocb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host pins
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic address_valid_strobe_n,
  input wire logic [12:0] addr_in,
  input wire logic [15:0] data_in,
  // synchronised, active high
  ocb_strobe_if.src strb
);
  // ===========================================================================
  // synchroniser, first stage read only by the second
  logic [32:0] stage1;
  logic [32:0] stage2;
  wire [32:0] raw = {~chip_select_n, ~output_enable_n, ~write_enable_n, ~address_valid_strobe_n, addr_in, data_in};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= 33'h0;
      stage2 <= 33'h0;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
    end
  end
  // data and address are skewed like the strobes; the host holds them stable around its strobes
  assign strb.cs = stage2[32];
  assign strb.oe = stage2[31];
  assign strb.we = stage2[30];
  assign strb.avd = stage2[29];
  assign strb.addr = stage2[28:16];
  assign strb.wdata = stage2[15:0];
endmodule : ocb_pin_sync

// file: hdl/ocb_output_control.sv
// top: output control register, key latch, boot block reads and not-ready pin
// Behaviour
// [R01] register resets only on hardware reset
// [R02] every cascaded device accepts register writes
// [R03] bit 0 gates not-ready during soft download
// [R04] power-on reset sets bit 0, holds not-ready
// [R05] lock is external input or key latch
// [R06] key latch sets by write, never clears; the code clears it on hardware reset
// [R07] first fetches answered from boot block
// [R08] held strobes with stepping address burst-read
// [R09] after boot, clock follows host strobes
// [R10] host supplies 13 address, 8 data, strobes; the code takes 16 data bits
// [R11] host maps device into 8KB window
// [R12] not-ready tells host when first access allowed
// [R13] lock low refuses protection key
// [R14] address-valid falling edge enters multiplexed mode
// [R15] reserved bits read zero, ignore writes
`timescale 1ns/100ps
module ocb_output_control
  import ocb_pkg::*;
(
  // clock and hardware reset
  input wire logic clk,
  input wire logic rst_b,
  // host bus pins
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic address_valid_strobe_n,
  input wire logic [12:0] addr_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  // straps and status pins
  input wire logic power_on_reset_in_n,
  input wire logic soft_reset_req,
  input wire logic [1:0] cascade_position_straps,
  input wire logic lock_in_n,
  output logic not_ready_n,
  // internal status
  output logic key_use_allowed,
  output logic mux_mode,
  output logic boot_done,
  output logic strobe_clock_mode
);
  // ===========================================================================
  // pin synchronisation
  ocb_strobe_if strb ();
  logic por_s1;
  logic por_s2;
  logic lock_s1;
  logic lock_s2;
  logic soft_s1;
  logic soft_s2;
  ocb_pin_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n),
    .address_valid_strobe_n(address_valid_strobe_n),
    .addr_in(addr_in),
    .data_in(data_in),
    .strb(strb)
  );
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {por_s1, por_s2, lock_s1, lock_s2, soft_s1, soft_s2} <= 6'h0;
    end else begin
      por_s1 <= ~power_on_reset_in_n;
      por_s2 <= por_s1;
      lock_s1 <= lock_in_n;
      lock_s2 <= lock_s1;
      soft_s1 <= soft_reset_req;
      soft_s2 <= soft_s1;
    end
  end
  // ===========================================================================
  // decode
  function automatic logic hit_ctrl(input logic [12:0] a);
    hit_ctrl = (a == OCB_ADDR_OUT_CTRL);
  endfunction : hit_ctrl
  logic we_d;
  logic avd_d;
  logic soft_d;
  logic [12:0] addr_d;
  // straps are not compared: a broadcast write lands in every cascaded device
  wire ctrl_write = strb.cs & strb.we & ~we_d & hit_ctrl(strb.addr); // R02
  wire read_active = strb.cs & strb.oe;
  wire soft_start = soft_s2 & ~soft_d;
  wire avd_fall = strb.avd & ~avd_d; // R14
  wire boot_hit = (strb.addr < 13'(OCB_BOOT_WORDS)) & ~boot_done; // R07
  // ===========================================================================
  // output control register; only rst_b resets it, soft download leaves it alone
  logic busy_en;
  logic key_latch;
  wire [7:0] ctrl_rd = {3'h0, key_latch, 3'h0, busy_en}; // R15
  wire [7:0] wmasked = strb.wdata[7:0] & OCB_OUT_CTRL_WMASK;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_en <= OCB_OUT_CTRL_RESET[OCB_BIT_BUSY_EN]; // R01
      key_latch <= OCB_OUT_CTRL_RESET[OCB_BIT_KEY_LATCH];
    end else begin
      if (por_s2) begin
        busy_en <= 1'b1; // R04
      end else if (ctrl_write) begin
        busy_en <= wmasked[OCB_BIT_BUSY_EN]; // R03
      end
      if (ctrl_write && wmasked[OCB_BIT_KEY_LATCH]) begin
        key_latch <= 1'b1; // R06
      end
    end
  end
  // ===========================================================================
  // boot download engine
  typedef enum logic [1:0] {OCB_IDLE, OCB_LOAD, OCB_READY} ocb_state_t;
  ocb_state_t state;
  ocb_state_t next_state;
  logic [OCB_CNT_W-1:0] dl_cnt;
  logic por_dl;
  // a soft start drops the power-on hold at once, so no one-cycle busy pulse leaks out with bit 0 clear
  wire soft_entry = soft_start & (state == OCB_READY);
  always_comb begin
    next_state = state;
    case (state)
      OCB_IDLE: next_state = OCB_LOAD;
      OCB_LOAD: if (dl_cnt == OCB_CNT_W'(OCB_DOWNLOAD_CYC - 1)) next_state = OCB_READY;
      OCB_READY: if (por_s2 || soft_start) next_state = OCB_LOAD;
      default: next_state = OCB_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= OCB_IDLE;
      dl_cnt <= '0;
      por_dl <= 1'b1;
      we_d <= 1'b0;
      avd_d <= 1'b0;
      soft_d <= 1'b0;
      addr_d <= 13'h0;
    end else begin
      state <= next_state;
      we_d <= strb.we;
      avd_d <= strb.avd;
      soft_d <= soft_s2;
      addr_d <= strb.addr;
      dl_cnt <= (state == OCB_LOAD && next_state == OCB_LOAD) ? dl_cnt + 1'b1 : '0;
      if (por_s2) begin
        por_dl <= 1'b1;
      end else if (soft_entry) begin
        por_dl <= 1'b0;
      end
    end
  end
  // ===========================================================================
  // boot block memory, filled by software writes below the window
  logic [15:0] boot_mem [OCB_BOOT_WORDS];
  always_ff @(posedge clk) begin
    if (strb.cs && strb.we && !we_d && strb.addr < 13'(OCB_BOOT_WORDS)) begin
      boot_mem[strb.addr[OCB_BOOT_AW-1:0]] <= strb.wdata;
    end
  end
  // ===========================================================================
  // status and outputs, all registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      not_ready_n <= 1'b0;
      key_use_allowed <= 1'b0;
      mux_mode <= 1'b0;
      boot_done <= 1'b0;
      strobe_clock_mode <= 1'b0;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
    end else begin
      // por download always holds not-ready; soft download only when bit 0 set
      not_ready_n <= ~((next_state != OCB_READY) & ((por_dl & ~soft_entry) | busy_en | por_s2)); // R03 R04 R12
      key_use_allowed <= lock_s2 | key_latch; // R05 R13
      if (avd_fall) begin
        mux_mode <= 1'b1; // R14
      end
      // boot ends with the first read outside the boot block once the download is done
      if (state == OCB_READY && read_active && strb.addr >= 13'(OCB_BOOT_WORDS)) begin
        boot_done <= 1'b1;
      end
      strobe_clock_mode <= boot_done; // R09
      data_oe <= read_active;
      // data follows each address step while strobes stay held
      if (read_active && hit_ctrl(strb.addr)) begin
        data_out <= {8'h00, ctrl_rd};
      end else if (read_active && boot_hit) begin
        data_out <= boot_mem[strb.addr[OCB_BOOT_AW-1:0]]; // R07 R08
      end else if (read_active) begin
        data_out <= 16'h0000;
      end
    end
  end
  // ===========================================================================
  // checks
  sequence s_write_set_lock;
    ctrl_write && wmasked[OCB_BIT_KEY_LATCH];
  endsequence
  AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (!rst_b) key_latch |=> key_latch) // R06
    else $error("key latch cleared without reset");
  AST_LOCK_SET: assert property (@(posedge clk) disable iff (!rst_b) s_write_set_lock |=> key_latch) // R06
    else $error("key latch not set by write");
  AST_LOCK_OR: assert property (@(posedge clk) disable iff (!rst_b) // R05
      1'b1 |=> key_use_allowed == ($past(lock_s2) | $past(key_latch)))
    else $error("lock is not the or of pin and latch");
  AST_POR_SETS_BUSY: assert property (@(posedge clk) disable iff (!rst_b) por_s2 |=> busy_en) // R04
    else $error("power-on reset did not set busy enable");
  AST_POR_NOT_READY: assert property (@(posedge clk) disable iff (!rst_b) por_s2 |=> ##1 !not_ready_n) // R04
    else $error("not-ready not asserted after power-on reset");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_b) ctrl_rd[7:5] == 3'h0 && !ctrl_rd[3]) // R15
    else $error("reserved bits not zero");
  AST_SOFT_QUIET: assert property (@(posedge clk) disable iff (!rst_b) // R03
      (state == OCB_LOAD && !busy_en && !por_dl && !por_s2) |=> not_ready_n)
    else $error("not-ready asserted with busy enable clear");
  AST_SOFT_ENTRY_QUIET: assert property (@(posedge clk) disable iff (!rst_b) // R03
      (soft_entry && !busy_en && !por_s2) |=> not_ready_n)
    else $error("not-ready pulsed at soft start with busy enable clear");
  AST_MUX_ENTRY: assert property (@(posedge clk) disable iff (!rst_b) avd_fall |=> mux_mode) // R14
    else $error("multiplexed mode not entered");
  AST_BURST_STEP: assert property (@(posedge clk) disable iff (!rst_b) // R08
      (read_active && boot_hit && !hit_ctrl(strb.addr)) |=>
      data_oe && data_out == $past(boot_mem[strb.addr[OCB_BOOT_AW-1:0]]))
    else $error("burst read not answered");
  AST_DL_ENDS: assert property (@(posedge clk) disable iff (!rst_b) // R04
      (state == OCB_LOAD && dl_cnt == OCB_CNT_W'(OCB_DOWNLOAD_CYC - 1)) |=> state == OCB_READY)
    else $error("download did not end on count");
endmodule : ocb_output_control

// file: verif/ocb_host_model.sv
// host model: drives the asynchronous memory bus strobes and samples read data
`timescale 1ns/100ps
module ocb_host_model (
  // clock
  input wire logic clk,
  // host pins
  output logic cs_n,
  output logic oe_n,
  output logic we_n,
  output logic avd_n,
  output logic [12:0] addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  initial begin
    cs_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    avd_n = 1'b1;
    addr = 13'h0000;
    wdata = 16'h0000;
  end
  // =====================================================
  // bus cycles; strobes stand 6 clocks since the pins pass a synchroniser
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    we_n <= 1'b0;
    addr <= a;
    wdata <= d;
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    we_n <= 1'b1;
    wdata <= ~d; // a released bus must not show the old value
    repeat (4) @(posedge clk);
  endtask : wr
  // strobes stay asserted on return, so calls in a row form a burst
  task automatic rd(input logic [12:0] a, output logic [15:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    addr <= a;
    repeat (6) @(posedge clk);
    d = rdata;
  endtask : rd
  task automatic idle;
    cs_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : idle
  task automatic avd_pulse;
    avd_n <= 1'b0;
    repeat (4) @(posedge clk);
    avd_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : avd_pulse
endmodule : ocb_host_model

// file: verif/test_output_control_boot_lock.sv
// testbench: register, key latch, boot burst and not-ready checks
`timescale 1ns/100ps
module test_output_control_boot_lock;
  import ocb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_n = 1'b1;
  logic soft_req = 1'b0;
  logic [1:0] straps = 2'h0;
  logic lock_n = 1'b1;
  logic cs_n, oe_n, we_n, avd_n, data_oe, not_ready_n, key_ok, mux_mode, boot_done, clk_mode;
  logic [12:0] addr;
  logic [15:0] wdata, rdata, rd_val;
  logic [15:0] boot_w [4];
  logic [7:0] reg_exp, d;
  logic [31:0] seed = 32'h68848EAD;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  ocb_host_model host (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .avd_n(avd_n), .addr(addr),
    .wdata(wdata), .rdata(rdata));
  ocb_output_control uut (.clk(clk), .rst_b(rst_b), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .write_enable_n(we_n), .address_valid_strobe_n(avd_n), .addr_in(addr), .data_in(wdata),
    .data_out(rdata), .data_oe(data_oe), .power_on_reset_in_n(por_n), .soft_reset_req(soft_req),
    .cascade_position_straps(straps), .lock_in_n(lock_n), .not_ready_n(not_ready_n),
    .key_use_allowed(key_ok), .mux_mode(mux_mode), .boot_done(boot_done), .strobe_clock_mode(clk_mode));
  // =====================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // key latch bit can only stay set; reserved bits never take a write
  function automatic logic [7:0] exp_reg(input logic [7:0] old, input logic [7:0] w);
    return (old & (8'h01 << OCB_BIT_KEY_LATCH)) | (w & OCB_OUT_CTRL_WMASK);
  endfunction : exp_reg
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_ready;
    for (int i = 0; i < 300 && not_ready_n !== 1'b1; i++) @(posedge clk);
    chk("not_ready_n", {15'h0, not_ready_n}, 16'h0001);
  endtask : wait_ready
  task automatic rdreg;
    host.rd(OCB_ADDR_OUT_CTRL, rd_val);
    chk("data_oe_on", {15'h0, data_oe}, 16'h0001);
    host.idle();
    chk("data_oe_off", {15'h0, data_oe}, 16'h0000);
    chk("out_ctrl", rd_val, {8'h00, reg_exp});
  endtask : rdreg
  task automatic soft_pulse;
    soft_req <= 1'b1;
    @(posedge clk);
    soft_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : soft_pulse
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // =====================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("busy_after_por", {15'h0, not_ready_n}, 16'h0000);
    wait_ready();
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      boot_w[i] = seed[15:0];
      host.wr(OCB_ADDR_BOOT_LO + 13'(i), boot_w[i]);
    end
    for (int i = 0; i < 4; i++) begin
      host.rd(OCB_ADDR_BOOT_LO + 13'(i), rd_val);
      chk("boot_word", rd_val, boot_w[i]);
    end
    chk("boot_done_early", {15'h0, boot_done}, 16'h0000);
    host.idle();
    reg_exp = 8'h01;
    rdreg();
    chk("strobe_clock", {14'h0, boot_done, clk_mode}, 16'h0003);
    host.rd(13'h0800, rd_val);
    host.idle();
    chk("unmapped", rd_val, 16'h0000);
    $display("done boot, checks %0d", n_checks);
    // random writes with corners: clear attempts before and after setting the key latch
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      d = (i == 0 || i == 2) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
      straps <= seed[9:8];
      lock_n <= seed[10];
      host.wr(OCB_ADDR_OUT_CTRL, {seed[31:24], d});
      reg_exp = exp_reg(reg_exp, d);
      rdreg();
      chk("key_use", {15'h0, key_ok}, {15'h0, lock_n | reg_exp[OCB_BIT_KEY_LATCH]});
    end
    $display("done register, checks %0d", n_checks);
    host.wr(OCB_ADDR_OUT_CTRL, 16'h0001);
    reg_exp = exp_reg(reg_exp, 8'h01);
    soft_pulse();
    chk("soft_busy_on", {15'h0, not_ready_n}, 16'h0000);
    wait_ready();
    rdreg();
    host.wr(OCB_ADDR_OUT_CTRL, 16'h0000);
    reg_exp = exp_reg(reg_exp, 8'h00);
    soft_pulse();
    chk("soft_busy_off", {15'h0, not_ready_n}, 16'h0001);
    repeat (OCB_DOWNLOAD_CYC + 20) @(posedge clk);
    por_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("por_busy", {15'h0, not_ready_n}, 16'h0000);
    por_n <= 1'b1;
    wait_ready();
    reg_exp = reg_exp | 8'h01;
    rdreg();
    $display("done resets, checks %0d", n_checks);
    host.avd_pulse();
    chk("mux_mode", {15'h0, mux_mode}, 16'h0001);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    wait_ready();
    reg_exp = 8'h01;
    rdreg();
    chk("key_after_rst", {15'h0, key_ok}, {15'h0, lock_n});
    $display("done hardware reset, checks %0d", n_checks);
    report_and_stop();
  end
endmodule : test_output_control_boot_lock
